// file: shared/tcc_defs.svh
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
// Contract
// - Three identical channels, each with a 16-bit up-counter.
// - Internal clocks are master clock /2, /8, /32, /128 and slow clock.
// - Counter adds one on each rising edge of its count clock.
// - Wrap from all ones to zero sets the overflow flag.
// - Live count readable any time without stopping it.
// - Trigger zeroes the counter on the next valid count edge.
// - Block mode routes each external clock from a pin or another line A.
// - Clock select picks one of five internal or three external clocks.
// - Invert bit makes counting use the opposite edge.
// - Burst gates the clock with a chosen external clock input high.
// - Control commands enable or disable the counter clock.
// - Capture B load disables the clock when its mode bit is set.
// - Compare C match disables the clock in waveform when bit set.
// - While disabled, start and stop are ignored; only enable restores.
// - Status shows a clock-enabled bit while the clock is enabled.
// - Every trigger starts the clock when the clock is enabled; the code lets a stop event in the same cycle win.
// - Capture B load or compare C match stops clock when bit set.
// - Mode bit picks capture or waveform; capture makes A and B inputs.
// - Waveform drives A always, B unless B is the external trigger.
// - Three common triggers plus one external; each resets and starts.
// - Each channel drives its own interrupt output.
// - One block control write starts all channels together.
// - Software trigger command bit triggers that channel.
// - Block sync bit triggers all channels like a software trigger.
// - Compare C match triggers when compare-trigger bit is set.
// - Any trigger acts at the next active count clock edge.
`define TCC_OFF_CTRL 6'h00
`define TCC_OFF_MODE 6'h04
`define TCC_OFF_COUNT 6'h10
`define TCC_OFF_CAPB 6'h18
`define TCC_OFF_CMPC 6'h1C
`define TCC_OFF_STATUS 6'h20
`define TCC_OFF_IEN 6'h24
`define TCC_OFF_IDIS 6'h28
`define TCC_OFF_IMASK 6'h2C
`define TCC_OFF_BLK_CTRL 8'hC0
`define TCC_OFF_BLK_MODE 8'hC4
`define TCC_CTRL_EN 0
`define TCC_CTRL_DIS 1
`define TCC_CTRL_SWT 2
`define TCC_BLK_SYNC 0
`define TCC_MODE_INV 3
`define TCC_MODE_STOP 6
`define TCC_MODE_DIS 7
`define TCC_MODE_ABSEL 10
`define TCC_MODE_ETEN 12
`define TCC_MODE_CTRG 14
`define TCC_MODE_WAVE 15
`define TCC_STAT_CLKON 16
`define TCC_MODE_MASK 32'h0003_DFFF
`define TCC_MODE_RST 32'h0000_0000
`define TCC_BLK_MODE_RST 6'h00
`define TCC_CMPC_RST 16'h0000
`define TCC_CNT_MAX 16'hFFFF
`endif

// file: shared/tcc_pkg.sv
package tcc_pkg;
    typedef logic [15:0] tcc_count_t;
    typedef enum logic [1:0] {
        TCC_EDGE_NONE = 2'h0,
        TCC_EDGE_RISE = 2'h1,
        TCC_EDGE_FALL = 2'h3,
        TCC_EDGE_BOTH = 2'h2
    } tcc_edge_e;
endpackage

// file: design/tcc_core.sv
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.svh"
module tcc_core #(
    parameter int CHANNELS = 3
) (
    // Clock, reset, freeze
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Avalon-MM slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Board clocks
    input wire logic slow_clk_in,
    input wire logic [2:0] ext_clock_pins_in,
    // I/O lines A and B
    input wire logic [2:0] io_line_a_in,
    output logic [2:0] io_line_a_out,
    output logic [2:0] io_line_a_oe_out,
    input wire logic [2:0] io_line_b_in,
    output logic [2:0] io_line_b_out,
    output logic [2:0] io_line_b_oe_out,
    // Channel interrupts
    output logic [2:0] irq_out
);
    logic [9:0] sync_a;
    logic [9:0] sync_b;
    logic [6:0] presc;
    logic bus_ack;
    logic bus_req;
    logic wr_hit;
    logic rd_hit;
    logic [1:0] ch_sel;
    logic [5:0] reg_sel;
    logic [31:0] wmask;
    logic [31:0] wdata;
    logic [31:0] rd_mux;
    logic [5:0] blk_mode;
    logic sync_all;
    logic slow_s;
    logic [2:0] ext_s;
    logic [2:0] ioa_s;
    logic [2:0] iob_s;
    logic [2:0] xclk;
    logic [2:0] ioa_lvl;
    logic [2:0] iob_lvl;
    logic [31:0] mode [CHANNELS];
    tcc_pkg::tcc_count_t cnt [CHANNELS];
    tcc_pkg::tcc_count_t capb [CHANNELS];
    tcc_pkg::tcc_count_t cmpc [CHANNELS];
    logic [3:0] flags [CHANNELS];
    logic [3:0] imask [CHANNELS];
    logic [2:0] clk_on;
    logic [2:0] started;
    logic [2:0] trig_pend;
    logic [2:0] lvl_prev;
    logic [2:0] ioa_prev;
    logic [2:0] ext_prev;
    logic [2:0] ioa_q;
    logic [2:0] iob_q;

    // Edge match for a two-bit edge field
    function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
        logic hit;
        hit = 1'b0;
        case (tcc_pkg::tcc_edge_e'(sel))
            tcc_pkg::TCC_EDGE_RISE: hit = now & ~was;
            tcc_pkg::TCC_EDGE_FALL: hit = ~now & was;
            tcc_pkg::TCC_EDGE_BOTH: hit = now ^ was;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Two-stage synchronisers for every pin input
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_a <= 10'h000;
            sync_b <= 10'h000;
        end else if (ce_in) begin
            sync_a <= {slow_clk_in, ext_clock_pins_in, io_line_a_in, io_line_b_in};
            sync_b <= sync_a;
        end
    end
    assign slow_s = sync_b[9];
    assign ext_s = sync_b[8:6];
    assign ioa_s = sync_b[5:3];
    assign iob_s = sync_b[2:0];

    // Shared prescaler for internal clocks
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            presc <= 7'h00;
        end else if (ce_in) begin
            presc <= presc + 7'h01;
        end
    end

    // Bus handshake: one wait cycle, then answer
    assign bus_req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = bus_req & ~bus_ack;
    assign wr_hit = avs_write_in & bus_ack & ce_in;
    assign rd_hit = avs_read_in & bus_ack & ce_in;
    assign ch_sel = avs_address_in[7:6];
    assign reg_sel = avs_address_in[5:0];
    assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    assign wdata = avs_writedata_in & wmask;
    assign sync_all = wr_hit & (avs_address_in == `TCC_OFF_BLK_CTRL) & wdata[`TCC_BLK_SYNC];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_ack <= 1'b0;
        end else if (ce_in) begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    // Read mux, unmapped reads give zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (avs_address_in == `TCC_OFF_BLK_MODE) begin
            rd_mux = {26'h000_0000, blk_mode};
        end else if (ch_sel != 2'h3) begin
            case (reg_sel)
                `TCC_OFF_MODE: rd_mux = mode[ch_sel];
                `TCC_OFF_COUNT: rd_mux = {16'h0000, cnt[ch_sel]};
                `TCC_OFF_CAPB: rd_mux = {16'h0000, capb[ch_sel]};
                `TCC_OFF_CMPC: rd_mux = {16'h0000, cmpc[ch_sel]};
                `TCC_OFF_STATUS: rd_mux = {15'h0000, clk_on[ch_sel], 12'h000, flags[ch_sel]};
                `TCC_OFF_IMASK: rd_mux = {28'h000_0000, imask[ch_sel]};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Read data captured in the wait cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (ce_in && avs_read_in && !bus_ack) begin
            avs_readdata_out <= rd_mux;
        end
    end

    // Block mode register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            blk_mode <= `TCC_BLK_MODE_RST;
        end else if (wr_hit && avs_address_in == `TCC_OFF_BLK_MODE) begin
            blk_mode <= (blk_mode & ~wmask[5:0]) | wdata[5:0];
        end
    end

    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        localparam int O1 = (c == 0) ? 1 : 0;
        localparam int O2 = (c == 2) ? 1 : 2;
        logic wave;
        logic [2:0] cks;
        logic [1:0] burst;
        logic [1:0] trg_edge;
        logic [1:0] evt_sel;
        logic [1:0] capb_edge;
        logic raw_lvl;
        logic cnt_lvl;
        logic gate;
        logic tick;
        logic ext_src;
        logic ext_trig;
        logic capb_load;
        logic cmpc_evt;
        logic ovf_evt;
        logic sw_trig;
        logic trig_req;
        logic stop_evt;
        logic dis_evt;
        logic ch_wr;
        logic cmd_en;
        logic cmd_dis;
        logic [3:0] set_f;
        logic [3:0] clr_f;
        tcc_pkg::tcc_count_t next_cnt;

        assign wave = mode[c][`TCC_MODE_WAVE];
        assign cks = mode[c][2:0];
        assign burst = mode[c][5:4];
        assign trg_edge = mode[c][9:8];
        assign evt_sel = mode[c][11:10];
        assign capb_edge = mode[c][17:16];
        assign ch_wr = wr_hit & (ch_sel == 2'(c));

        // Chaining source for external clock input c
        always_comb begin
            case (blk_mode[2*c+1 -: 2])
                2'h0: xclk[c] = ext_s[c];
                2'h2: xclk[c] = ioa_lvl[O1];
                2'h3: xclk[c] = ioa_lvl[O2];
                default: xclk[c] = 1'b0;
            endcase
        end

        // Line levels seen by the channel
        assign ioa_lvl[c] = wave ? ioa_q[c] : ioa_s[c];
        assign iob_lvl[c] = io_line_b_oe_out[c] ? iob_q[c] : iob_s[c];

        // Count clock selection, invert and burst gate
        always_comb begin
            case (cks)
                3'h0: raw_lvl = presc[0];
                3'h1: raw_lvl = presc[2];
                3'h2: raw_lvl = presc[4];
                3'h3: raw_lvl = presc[6];
                3'h4: raw_lvl = slow_s;
                3'h5: raw_lvl = xclk[0];
                3'h6: raw_lvl = xclk[1];
                default: raw_lvl = xclk[2];
            endcase
        end
        assign gate = (burst == 2'h0) ? 1'b1 : xclk[burst - 2'h1];
        assign cnt_lvl = (raw_lvl ^ mode[c][`TCC_MODE_INV]) & gate;
        assign tick = cnt_lvl & ~lvl_prev[c] & clk_on[c] & started[c];

        // External trigger and capture B events
        always_comb begin
            if (!wave) begin
                ext_src = mode[c][`TCC_MODE_ABSEL] ? ioa_lvl[c] : iob_lvl[c];
            end else begin
                case (evt_sel)
                    2'h0: ext_src = iob_s[c];
                    2'h1: ext_src = xclk[0];
                    2'h2: ext_src = xclk[1];
                    default: ext_src = xclk[2];
                endcase
            end
        end
        assign ext_trig = edge_hit(trg_edge, ext_src, ext_prev[c]) & (~wave | mode[c][`TCC_MODE_ETEN]);
        assign capb_load = ~wave & edge_hit(capb_edge, ioa_lvl[c], ioa_prev[c]);

        // Next count, compare and wrap
        assign next_cnt = trig_pend[c] ? 16'h0000 : cnt[c] + 16'h0001;
        assign cmpc_evt = tick & (next_cnt == cmpc[c]);
        assign ovf_evt = tick & ~trig_pend[c] & (cnt[c] == `TCC_CNT_MAX);

        // Trigger sources
        assign sw_trig = ch_wr & (reg_sel == `TCC_OFF_CTRL) & wdata[`TCC_CTRL_SWT];
        assign trig_req = sw_trig | sync_all | ext_trig
                        | (cmpc_evt & mode[c][`TCC_MODE_CTRG]);
        assign stop_evt = mode[c][`TCC_MODE_STOP] & (wave ? cmpc_evt : capb_load);
        assign dis_evt = mode[c][`TCC_MODE_DIS] & (wave ? cmpc_evt : capb_load);
        assign cmd_en = ch_wr & (reg_sel == `TCC_OFF_CTRL) & wdata[`TCC_CTRL_EN];
        assign cmd_dis = ch_wr & (reg_sel == `TCC_OFF_CTRL) & wdata[`TCC_CTRL_DIS];

        // Edge history
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                lvl_prev[c] <= 1'b0;
                ioa_prev[c] <= 1'b0;
                ext_prev[c] <= 1'b0;
            end else if (ce_in) begin
                lvl_prev[c] <= cnt_lvl;
                ioa_prev[c] <= ioa_lvl[c];
                ext_prev[c] <= ext_src;
            end
        end

        // Clock enable state, disable wins
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                clk_on[c] <= 1'b0;
            end else if (ce_in) begin
                if (cmd_dis || dis_evt) begin
                    clk_on[c] <= 1'b0;
                end else if (cmd_en) begin
                    clk_on[c] <= 1'b1;
                end
            end
        end

        // Start and stop, only while enabled
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                started[c] <= 1'b0;
            end else if (ce_in && clk_on[c]) begin
                if (stop_evt) begin
                    started[c] <= 1'b0;
                end else if (trig_req) begin
                    started[c] <= 1'b1;
                end
            end
        end

        // Pending trigger, consumed at the next count edge
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                trig_pend[c] <= 1'b0;
            end else if (ce_in) begin
                trig_pend[c] <= (trig_pend[c] & ~tick) | (trig_req & clk_on[c]);
            end
        end

        // Counter
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                cnt[c] <= 16'h0000;
            end else if (ce_in && tick) begin
                cnt[c] <= next_cnt;
            end
        end

        // Capture B register
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                capb[c] <= 16'h0000;
            end else if (ce_in && capb_load) begin
                capb[c] <= cnt[c];
            end
        end

        // Mode and compare C registers
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                mode[c] <= `TCC_MODE_RST;
                cmpc[c] <= `TCC_CMPC_RST;
            end else if (ch_wr) begin
                if (reg_sel == `TCC_OFF_MODE) begin
                    mode[c] <= ((mode[c] & ~wmask) | wdata) & `TCC_MODE_MASK;
                end
                if (reg_sel == `TCC_OFF_CMPC) begin
                    cmpc[c] <= (cmpc[c] & ~wmask[15:0]) | wdata[15:0];
                end
            end
        end

        // Status flags: clear only what was read, set wins
        assign set_f = {ext_trig, capb_load, cmpc_evt, ovf_evt};
        assign clr_f = (rd_hit && ch_sel == 2'(c) && reg_sel == `TCC_OFF_STATUS)
                     ? avs_readdata_out[3:0] : 4'h0;
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                flags[c] <= 4'h0;
            end else if (ce_in) begin
                flags[c] <= (flags[c] & ~clr_f) | set_f;
            end
        end

        // Interrupt mask set and clear
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                imask[c] <= 4'h0;
            end else if (ch_wr) begin
                if (reg_sel == `TCC_OFF_IEN) begin
                    imask[c] <= imask[c] | wdata[3:0];
                end else if (reg_sel == `TCC_OFF_IDIS) begin
                    imask[c] <= imask[c] & ~wdata[3:0];
                end
            end
        end
        assign irq_out[c] = |(flags[c] & imask[c]);

        // Line outputs: A toggles on compare C, B on wrap
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                ioa_q[c] <= 1'b0;
                iob_q[c] <= 1'b0;
            end else if (ce_in && wave) begin
                ioa_q[c] <= ioa_q[c] ^ cmpc_evt;
                iob_q[c] <= iob_q[c] ^ ovf_evt;
            end
        end
        assign io_line_a_out[c] = ioa_q[c];
        assign io_line_b_out[c] = iob_q[c];
        assign io_line_a_oe_out[c] = wave;
        assign io_line_b_oe_out[c] = wave & (evt_sel != 2'h0);
    end
endmodule // tcc_core
`default_nettype wire

// file: dv/tcc_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_core_checker (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Register bus
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // Lines and interrupts
    input wire logic [2:0] io_line_a_out,
    input wire logic [2:0] io_line_a_oe_out,
    input wire logic [2:0] io_line_b_oe_out,
    input wire logic [2:0] irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_one_wait;
        (avs_read_in || avs_write_in) && avs_waitrequest_out && ce_in |=> !avs_waitrequest_out;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus wait not one cycle");
    property p_idle;
        !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out;
    endproperty
    a_idle: assert property (p_idle) else $error("wait without request");
    property p_rd_stable;
        !avs_read_in |=> $stable(avs_readdata_out);
    endproperty
    a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
    property p_cnt_hi;
        avs_read_in && !avs_waitrequest_out && avs_address_in[5:0] == 6'h10 && avs_address_in[7:6] != 2'h3
            |-> avs_readdata_out[31:16] == 16'h0;
    endproperty
    a_cnt_hi: assert property (p_cnt_hi) else $error("count wider than 16 bits");
    property p_stat_rsv;
        avs_read_in && !avs_waitrequest_out && avs_address_in[5:0] == 6'h20 && avs_address_in[7:6] != 2'h3
            |-> avs_readdata_out[15:4] == 12'h0 && avs_readdata_out[31:17] == 15'h0;
    endproperty
    a_stat_rsv: assert property (p_stat_rsv) else $error("status spare bits set");
    property p_a_quiet;
        (~$past(io_line_a_oe_out) & (io_line_a_out ^ $past(io_line_a_out))) == 3'h0;
    endproperty
    a_a_quiet: assert property (p_a_quiet) else $error("undriven line A output moved");
    property p_oe_hold;
        !(avs_write_in && !avs_waitrequest_out) |=> $stable(io_line_a_oe_out) && $stable(io_line_b_oe_out);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("line direction changed alone");
    property p_irq_fall;
        |($past(irq_out) & ~irq_out) |-> ($past(avs_read_in) || $past(avs_write_in)) && !$past(avs_waitrequest_out);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped alone");
endmodule // tcc_core_checker
bind tcc_core tcc_core_checker u_tcc_core_checker (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .io_line_a_out(io_line_a_out), .io_line_a_oe_out(io_line_a_oe_out), .io_line_b_oe_out(io_line_b_oe_out),
    .irq_out(irq_out));
`default_nettype wire

// file: dv/tcc_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_board_model (
    // Clock
    input wire logic clk_in,
    // Line drive from the core
    input wire logic [2:0] a_out_in,
    input wire logic [2:0] a_oe_in,
    input wire logic [2:0] b_out_in,
    input wire logic [2:0] b_oe_in,
    // Board levels
    output logic slow_clk_out,
    output logic [2:0] pins_out,
    output logic [2:0] a_wire_out,
    output logic [2:0] b_wire_out
);
    logic [2:0] a_drv = 3'h0;
    logic [4:0] div = 5'h0;
    initial pins_out = 3'h0;
    // Free-running slow clock
    always @(posedge clk_in) begin
        div <= div + 5'h1;
    end
    assign slow_clk_out = div[4];
    // Resolved lines; B has a pull-down
    assign a_wire_out = (a_oe_in & a_out_in) | (~a_oe_in & a_drv);
    assign b_wire_out = b_oe_in & b_out_in;
    // Pulses, each level held three periods
    task automatic pulse(input int n, input logic [2:0] pm, input logic [2:0] am);
        repeat (n) begin
            pins_out <= pins_out | pm;
            a_drv <= a_drv | am;
            repeat (3) @(posedge clk_in);
            pins_out <= pins_out & ~pm;
            a_drv <= a_drv & ~am;
            repeat (3) @(posedge clk_in);
        end
    endtask
    // Steady pin levels
    task automatic set_pins(input logic [2:0] v);
        pins_out <= v;
        @(posedge clk_in);
    endtask
endmodule // tcc_board_model
`default_nettype wire

// file: dv/tcc_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.svh"
module tcc_core_tb_top;
    logic clk_in, rst_in, rd, wr, wreq, slow, ce;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [2:0] pins, a_in, a_out, a_oe, b_in, b_out, b_oe, irq;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int n_errors = 0;
    int checked = 0;
    int p;
    logic [15:0] v;
    tcc_core u_tcc_core (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .slow_clk_in(slow), .ext_clock_pins_in(pins),
        .io_line_a_in(a_in), .io_line_a_out(a_out), .io_line_a_oe_out(a_oe), .io_line_b_in(b_in),
        .io_line_b_out(b_out), .io_line_b_oe_out(b_oe), .irq_out(irq));
    tcc_board_model u_model (.clk_in(clk_in), .a_out_in(a_out), .a_oe_in(a_oe), .b_out_in(b_out),
        .b_oe_in(b_oe), .slow_clk_out(slow), .pins_out(pins), .a_wire_out(a_in), .b_wire_out(b_in));
    // Clock
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] ad(input logic [1:0] k, input logic [5:0] off);
        return {k, off};
    endfunction
    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Bus cycle; a read notes its expected value
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        if (!w) begin
            exp_q.push_back(d & m);
            msk_q.push_back(m);
        end
        addr <= a;
        wdata <= w ? d : 32'h0;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk_in);
        end while (wreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
        // One idle edge so the next call never reassigns the strobes
        @(posedge clk_in);
    endtask
    // Read results against the oldest note
    always @(posedge clk_in) begin
        if (rd && wreq === 1'b0 && exp_q.size() > 0) begin
            check(rdata & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    // Watchdog
    initial begin
        repeat (8000) @(posedge clk_in);
        n_errors++;
        complete_run();
    end
    // Main sequence
    initial begin
        rst_in = 1'b1;
        ce = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        void'($urandom(11));
        p = 3 + ($urandom % 6);
        v = 16'($urandom);
        idle(2);
        rst_in <= 1'b0;
        bus(1'b0, ad(0, `TCC_OFF_MODE), 32'h0, 32'hFFFFFFFF);
        bus(1'b0, ad(2, `TCC_OFF_CMPC), 32'h0, 32'hFFFFFFFF);
        bus(1'b0, 8'h30, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, ad(2, `TCC_OFF_CMPC), 32'(v), 32'h0);
        bus(1'b0, ad(2, `TCC_OFF_CMPC), 32'(v), 32'hFFFFFFFF);
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, ad(2'(k), `TCC_OFF_MODE), 32'h5, 32'h0);
            bus(1'b0, ad(2'(k), `TCC_OFF_STATUS), 32'h0, 32'h10000);
            bus(1'b1, ad(2'(k), `TCC_OFF_CTRL), 32'h1, 32'h0);
        end
        idle(2);
        for (int k = 0; k < 3; k++) bus(1'b0, ad(2'(k), `TCC_OFF_STATUS), 32'h10000, 32'h10000);
        u_model.pulse(2, 3'h1, 3'h0);
        idle(3);
        bus(1'b0, ad(1, `TCC_OFF_COUNT), 32'h0, 32'hFFFFFFFF);
        bus(1'b1, `TCC_OFF_BLK_CTRL, 32'h1, 32'h0);
        u_model.pulse(p, 3'h1, 3'h0);
        idle(3);
        for (int k = 0; k < 3; k++) bus(1'b0, ad(2'(k), `TCC_OFF_COUNT), 32'(p - 1), 32'hFFFFFFFF);
        bus(1'b1, ad(0, `TCC_OFF_CTRL), 32'h4, 32'h0);
        bus(1'b0, ad(0, `TCC_OFF_COUNT), 32'(p - 1), 32'hFFFFFFFF);
        u_model.pulse(1, 3'h1, 3'h0);
        idle(3);
        bus(1'b0, ad(0, `TCC_OFF_COUNT), 32'h0, 32'hFFFFFFFF);
        bus(1'b0, ad(1, `TCC_OFF_COUNT), 32'(p), 32'hFFFFFFFF);
        // Disable beats enable; trigger then ignored
        bus(1'b1, ad(1, `TCC_OFF_CTRL), 32'h3, 32'h0);
        idle(2);
        bus(1'b0, ad(1, `TCC_OFF_STATUS), 32'h0, 32'h10000);
        bus(1'b1, ad(1, `TCC_OFF_CTRL), 32'h4, 32'h0);
        u_model.pulse(2, 3'h1, 3'h0);
        idle(3);
        bus(1'b0, ad(1, `TCC_OFF_COUNT), 32'(p), 32'hFFFFFFFF);
        // Waveform compare stop with interrupt
        bus(1'b1, ad(0, `TCC_OFF_CMPC), 32'h4, 32'h0);
        bus(1'b1, ad(0, `TCC_OFF_IEN), 32'h2, 32'h0);
        bus(1'b0, ad(0, `TCC_OFF_IMASK), 32'h2, 32'hFFFFFFFF);
        bus(1'b1, ad(0, `TCC_OFF_MODE), 32'h8045, 32'h0);
        idle(1);
        check(32'({a_oe, b_oe}), 32'h8);
        bus(1'b1, ad(0, `TCC_OFF_CTRL), 32'h4, 32'h0);
        u_model.pulse(8, 3'h1, 3'h0);
        idle(3);
        check(32'(irq), 32'h1);
        check(32'({a_out, b_out}), 32'h8);
        bus(1'b0, ad(0, `TCC_OFF_COUNT), 32'h4, 32'hFFFFFFFF);
        bus(1'b0, ad(0, `TCC_OFF_STATUS), 32'h10002, 32'h10002);
        idle(1);
        check(32'(irq), 32'h0);
        // Compare also disables the clock
        bus(1'b1, ad(0, `TCC_OFF_MODE), 32'h80C5, 32'h0);
        bus(1'b1, ad(0, `TCC_OFF_CTRL), 32'h4, 32'h0);
        u_model.pulse(8, 3'h1, 3'h0);
        idle(3);
        bus(1'b0, ad(0, `TCC_OFF_COUNT), 32'h4, 32'hFFFFFFFF);
        bus(1'b0, ad(0, `TCC_OFF_STATUS), 32'h0, 32'h10000);
        // Compare match as trigger
        bus(1'b1, ad(0, `TCC_OFF_MODE), 32'hC005, 32'h0);
        bus(1'b1, ad(0, `TCC_OFF_CTRL), 32'h1, 32'h0);
        bus(1'b1, ad(0, `TCC_OFF_CTRL), 32'h4, 32'h0);
        u_model.pulse(8, 3'h1, 3'h0);
        idle(3);
        bus(1'b0, ad(0, `TCC_OFF_COUNT), 32'h2, 32'hFFFFFFFF);
        // Burst gate on external input 1
        u_model.set_pins(3'h2);
        bus(1'b1, ad(2, `TCC_OFF_MODE), 32'h25, 32'h0);
        bus(1'b1, ad(2, `TCC_OFF_CTRL), 32'h4, 32'h0);
        u_model.pulse(3, 3'h1, 3'h0);
        idle(3);
        bus(1'b0, ad(2, `TCC_OFF_COUNT), 32'h2, 32'hFFFFFFFF);
        // Frozen core ignores pulses
        ce <= 1'b0;
        u_model.pulse(3, 3'h1, 3'h0);
        ce <= 1'b1;
        idle(3);
        bus(1'b0, ad(2, `TCC_OFF_COUNT), 32'h2, 32'hFFFFFFFF);
        u_model.set_pins(3'h0);
        idle(3);
        u_model.pulse(3, 3'h1, 3'h0);
        idle(3);
        bus(1'b0, ad(2, `TCC_OFF_COUNT), 32'h2, 32'hFFFFFFFF);
        // Chain line A of channel 0 into channel 1
        bus(1'b1, ad(0, `TCC_OFF_MODE), 32'h0, 32'h0);
        idle(1);
        check(32'({a_oe, b_oe}), 32'h0);
        bus(1'b1, `TCC_OFF_BLK_MODE, 32'h8, 32'h0);
        bus(1'b1, ad(1, `TCC_OFF_MODE), 32'h6, 32'h0);
        bus(1'b1, ad(1, `TCC_OFF_CTRL), 32'h1, 32'h0);
        bus(1'b1, ad(1, `TCC_OFF_CTRL), 32'h4, 32'h0);
        u_model.pulse(4, 3'h0, 3'h1);
        idle(3);
        bus(1'b0, ad(1, `TCC_OFF_COUNT), 32'h3, 32'hFFFFFFFF);
        bus(1'b1, ad(2, `TCC_OFF_MODE), 32'h8400, 32'h0);
        idle(1);
        check(32'({a_oe, b_oe}), 32'h24);
        idle(2);
        complete_run();
    end
endmodule // tcc_core_tb_top
`default_nettype wire
